// *** rtl/csc_pkg.sv ***
/*
 Constants for the channel sequence configuration register group.
 Assumes byte-wide registers addressed by an 8-bit register address.
*/
package csc_pkg;
  localparam logic [7:0] ADDR_SCAN_CONTROL   = 8'h10;
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h11;
  localparam logic [7:0] ADDR_SCAN_CH_EN     = 8'h12;
  localparam logic [7:0] ADDR_ALERT_CH_EN    = 8'h14;
  localparam logic [7:0] ADDR_ALERT_SRC_MAP  = 8'h16;
  localparam int         RUN_BIT             = 4;
  localparam int         MODE_LSB            = 0;
  localparam int         MANUAL_LSB          = 0;
  localparam int         ZERO_CROSS_LSB      = 4;
  localparam int         MAP_RMS_BIT         = 1;
  localparam int         MAP_CRC_BIT         = 0;
  localparam logic [7:0] RESET_VALUE         = 8'h00;
  localparam logic [2:0] SEQ_REWIND          = 3'h7;
  localparam logic [7:0] SCAN_CONTROL_MASK   = 8'h13;
  localparam logic [7:0] ALERT_SRC_MAP_MASK  = 8'h03;
  localparam logic [1:0] MODE_MANUAL         = 2'h0;
  localparam logic [1:0] MODE_AUTO           = 2'h1;
  localparam logic [1:0] MODE_ON_THE_FLY     = 2'h2;
  localparam logic [3:0] CHANNEL_LIMIT       = 4'h8;
endpackage : csc_pkg

// *** rtl/csc_channel_sequence_config.sv ***
/*
 Register group for scan mode, sequencer, manual and zero-cross channel selection,
 and per-channel scan and alert enables, plus the channel chooser they steer.
 Assumes the serial front end delivers one-cycle write and read strobes on clk_i,
 and that conversion engine and comparator signals are on the same clock.
*/
`timescale 1ns/10ps
module csc_channel_sequence_config (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [7:0] pin_config_i,
  input  wire logic [7:0] gpio_level_i,
  input  wire logic       conv_done_i,
  input  wire logic       analog_zero_cross_i,
  input  wire logic [7:0] channel_alert_i,
  output logic      [2:0] conv_channel_o,
  output logic            conv_channel_valid_o,
  output logic      [1:0] scan_mode_o,
  output logic            sequencer_active_o,
  output logic            zero_cross_detect_o,
  output logic            alert_o,
  output logic      [1:0] alert_source_map_o
);

  logic [7:0] scan_control;
  logic [7:0] channel_select;
  logic [7:0] scan_channel_enable;
  logic [7:0] alert_channel_enable;
  logic [7:0] alert_source_map;
  logic [2:0] seq_channel;
  logic [2:0] next_seq_channel;
  logic       seq_found;
  logic [7:0] gpio_meta;
  logic [7:0] gpio_sync;
  logic [1:0] scan_mode;
  logic       sequencer_run;
  logic [3:0] manual_channel_id;
  logic [3:0] zero_cross_source_channel;
  logic       seq_running;

  assign scan_mode                 = scan_control[csc_pkg::MODE_LSB +: 2];
  assign sequencer_run             = scan_control[csc_pkg::RUN_BIT];
  assign manual_channel_id         = channel_select[csc_pkg::MANUAL_LSB +: 4];
  assign zero_cross_source_channel = channel_select[csc_pkg::ZERO_CROSS_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_control         <= csc_pkg::RESET_VALUE;
      channel_select       <= csc_pkg::RESET_VALUE;
      scan_channel_enable  <= csc_pkg::RESET_VALUE;
      alert_channel_enable <= csc_pkg::RESET_VALUE;
      alert_source_map     <= csc_pkg::RESET_VALUE;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        csc_pkg::ADDR_SCAN_CONTROL: begin
          scan_control <= reg_wdata_i & csc_pkg::SCAN_CONTROL_MASK;
        end
        csc_pkg::ADDR_CHANNEL_SELECT: begin
          channel_select <= reg_wdata_i;
        end
        csc_pkg::ADDR_SCAN_CH_EN: begin
          scan_channel_enable <= reg_wdata_i;
        end
        csc_pkg::ADDR_ALERT_CH_EN: begin
          alert_channel_enable <= reg_wdata_i;
        end
        csc_pkg::ADDR_ALERT_SRC_MAP: begin
          alert_source_map <= reg_wdata_i & csc_pkg::ALERT_SRC_MAP_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= csc_pkg::RESET_VALUE;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        csc_pkg::ADDR_SCAN_CONTROL:  reg_rdata_o <= scan_control & csc_pkg::SCAN_CONTROL_MASK;
        csc_pkg::ADDR_CHANNEL_SELECT: reg_rdata_o <= channel_select;
        csc_pkg::ADDR_SCAN_CH_EN:    reg_rdata_o <= scan_channel_enable;
        csc_pkg::ADDR_ALERT_CH_EN:   reg_rdata_o <= alert_channel_enable;
        csc_pkg::ADDR_ALERT_SRC_MAP: reg_rdata_o <= alert_source_map & csc_pkg::ALERT_SRC_MAP_MASK;
        default:                     reg_rdata_o <= csc_pkg::RESET_VALUE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto sequencer
  // run only in auto mode
  assign seq_running = (scan_mode == csc_pkg::MODE_AUTO) && sequencer_run
                       && (scan_channel_enable != 8'h00);

  // next enabled channel, ascending with wrap
  always_comb begin
    next_seq_channel = seq_channel;
    seq_found        = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      if (!seq_found && scan_channel_enable[3'(seq_channel + 3'(k))]) begin
        next_seq_channel = 3'(seq_channel + 3'(k));
        seq_found        = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_channel <= csc_pkg::SEQ_REWIND;
    end else if (!seq_running) begin
      // stop rewinds to lowest channel on restart
      seq_channel <= csc_pkg::SEQ_REWIND;
    end else if (conv_done_i) begin
      seq_channel <= next_seq_channel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_channel_o       <= 3'h0;
      conv_channel_valid_o <= 1'b0;
    end else begin
      case (scan_mode)
        csc_pkg::MODE_MANUAL: begin
          conv_channel_o       <= manual_channel_id[2:0];
          conv_channel_valid_o <= manual_channel_id < csc_pkg::CHANNEL_LIMIT;
        end
        csc_pkg::MODE_AUTO: begin
          conv_channel_o       <= seq_running ? next_seq_channel : 3'h0;
          conv_channel_valid_o <= seq_running;
        end
        csc_pkg::MODE_ON_THE_FLY: begin
          conv_channel_o       <= manual_channel_id[2:0];
          conv_channel_valid_o <= manual_channel_id < csc_pkg::CHANNEL_LIMIT;
        end
        default: begin
          conv_channel_o       <= 3'h0;
          conv_channel_valid_o <= 1'b0;
        end
      endcase
    end
  end

  assign scan_mode_o        = scan_mode;
  assign sequencer_active_o = seq_running;
  assign alert_source_map_o = alert_source_map[csc_pkg::MAP_RMS_BIT:csc_pkg::MAP_CRC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Zero-cross source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_meta <= 8'h00;
      gpio_sync <= 8'h00;
    end else begin
      gpio_meta <= gpio_level_i;
      gpio_sync <= gpio_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_cross_detect_o <= 1'b0;
    end else if (zero_cross_source_channel >= csc_pkg::CHANNEL_LIMIT) begin
      zero_cross_detect_o <= 1'b0;
    end else if (pin_config_i[zero_cross_source_channel[2:0]]) begin
      zero_cross_detect_o <= gpio_sync[zero_cross_source_channel[2:0]];
    end else begin
      zero_cross_detect_o <= analog_zero_cross_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert gating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_o <= 1'b0;
    end else begin
      alert_o <= |(channel_alert_i & alert_channel_enable);
    end
  end

endmodule : csc_channel_sequence_config

// *** tb/csc_sva.sv ***
/* Assertions on the channel sequence configuration group ports.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/10ps
module csc_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] pin_config_i,
  input wire logic       analog_zero_cross_i,
  input wire logic [7:0] channel_alert_i,
  input wire logic [2:0] conv_channel_o,
  input wire logic       conv_channel_valid_o,
  input wire logic [1:0] scan_mode_o,
  input wire logic       sequencer_active_o,
  input wire logic       zero_cross_detect_o,
  input wire logic       alert_o
);
  logic [7:0] scan_en, alert_en, zsrc;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies of written registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_en  <= 8'h00;
      alert_en <= 8'h00;
      zsrc     <= 8'h00;
    end else if (reg_write_i) begin
      if (reg_addr_i == 8'h12) scan_en <= reg_wdata_i;
      if (reg_addr_i == 8'h14) alert_en <= reg_wdata_i;
      if (reg_addr_i == 8'h11) zsrc <= reg_wdata_i;
    end
  end
  a_rsvd_read_zero: assert property (reg_read_i && reg_addr_i == 8'h10
    |=> (reg_rdata_o & 8'hec) == 8'h00) else $error("reserved bits set");
  a_mode_follows: assert property (reg_write_i && reg_addr_i == 8'h10
    |=> {6'h00, scan_mode_o} == ($past(reg_wdata_i) & 8'h03)) else $error("mode wrong");
  a_run_needs_auto: assert property (sequencer_active_o |-> scan_mode_o == 2'h1)
    else $error("active outside auto");
  a_manual_channel: assert property (reg_write_i && reg_addr_i == 8'h11
    && scan_mode_o == 2'h0 ##1 !reg_write_i
    |=> {5'h00, conv_channel_o} == ($past(reg_wdata_i, 2) & 8'h07)
    && conv_channel_valid_o == (($past(reg_wdata_i, 2) & 8'h0f) < 8'h08))
    else $error("manual channel wrong");
  a_alert_gated: assert property (alert_o ==
    |($past(channel_alert_i) & $past(alert_en))) else $error("alert wrong");
  a_zc_analog: assert property (!zsrc[7] && !pin_config_i[zsrc[6:4]]
    |=> zero_cross_detect_o == $past(analog_zero_cross_i)) else $error("zc wrong");
  a_zc_reserved: assert property (zsrc[7] |=> !zero_cross_detect_o)
    else $error("zc from reserved source");
  a_scan_enabled: assert property ((sequencer_active_o && !reg_write_i)[*4]
    |-> conv_channel_valid_o && scan_en[conv_channel_o]) else $error("bad scan channel");
  a_unmapped_zero: assert property (reg_read_i && !(reg_addr_i inside
    {8'h10, 8'h11, 8'h12, 8'h14, 8'h16}) |=> reg_rdata_o == 8'h00) else $error("unmapped");
  c_auto: cover property (sequencer_active_o && conv_channel_valid_o);
  c_alert: cover property (alert_o);
  c_zc_gpio: cover property (zero_cross_detect_o && pin_config_i != 8'h00);
endmodule : csc_sva
bind csc_channel_sequence_config csc_sva csc_sva_inst (.*);

// *** tb/csc_engine_model.sv ***
/* Conversion engine stand-in: answers a start with one done pulse.
   Assumes starts are spaced wider than LAT cycles. */
`timescale 1ns/10ps
module csc_engine_model #(
  parameter int LAT = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      conv_done_o
);
  int cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) cnt <= rst_i ? 0 : LAT;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  always_ff @(posedge clk_i) conv_done_o <= !rst_i && cnt == 1;
endmodule : csc_engine_model

// *** tb/tb_csc_channel_sequence_config.sv ***
/* Bench for the channel sequence configuration group.
   Assumes the package, design, checker and engine model compile first. */
`timescale 1ns/10ps
module tb_csc_channel_sequence_config;
  logic       clk_i, rst_i, reg_write_i, reg_read_i, conv_done_i, analog_zero_cross_i, start;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pin_config_i, gpio_level_i, channel_alert_i;
  logic [2:0] conv_channel_o;
  logic [1:0] scan_mode_o, alert_source_map_o;
  logic       conv_channel_valid_o, sequencer_active_o, zero_cross_detect_o, alert_o;
  int         n_mismatch, tests_run, i;
  logic [7:0] ta [6] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h16, 8'h13};
  logic [7:0] te [6] = '{8'h13, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00};
  csc_channel_sequence_config csc_channel_sequence_config_inst (.*);
  csc_engine_model #(.LAT(3)) csc_engine_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(start), .conv_done_o(conv_done_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    cyc(1);
    reg_write_i = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    reg_addr_i = a;
    reg_read_i = 1'b1;
    cyc(1);
    reg_read_i = 1'b0;
    chk("rdata", reg_rdata_o, exp);
    cyc(1);
  endtask : rd
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial begin
    {reg_write_i, reg_read_i, analog_zero_cross_i, start} = '0;
    {reg_addr_i, reg_wdata_i, pin_config_i, gpio_level_i, channel_alert_i} = '0;
    {n_mismatch, tests_run} = '0;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    for (i = 0; i < 6; i++) rd(ta[i], 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(ta[i], 8'hff);
      rd(ta[i], te[i]);
    end
    chk("map_out", {6'h00, alert_source_map_o}, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 8'(i));
      chk("mode", {6'h00, scan_mode_o}, 8'(i));
      chk("active", {7'h00, sequencer_active_o}, 8'h00);
    end
    analog_zero_cross_i = 1'b1;
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h85);
    chk("manual", {4'h0, conv_channel_valid_o, conv_channel_o}, 8'h0d);
    chk("zc_off", {7'h00, zero_cross_detect_o}, 8'h00);
    wr(8'h11, 8'h89);
    chk("reserved_id", {7'h00, conv_channel_valid_o}, 8'h00);
    wr(8'h12, 8'h24);
    wr(8'h10, 8'h11);
    for (i = 0; i < 10 && conv_channel_o !== 3'h2; i++) cyc(1);
    if (i == 10) n_mismatch++;
    chk("seq_first", {4'h0, conv_channel_valid_o, conv_channel_o}, 8'h0a);
    for (i = 0; i < 2; i++) begin
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      cyc(8);
      chk("seq_step", {5'h00, conv_channel_o}, i == 0 ? 8'h05 : 8'h02);
    end
    wr(8'h10, 8'h01);
    chk("seq_stop", {7'h00, sequencer_active_o}, 8'h00);
    wr(8'h10, 8'h12);
    chk("run_not_auto", {7'h00, sequencer_active_o}, 8'h00);
    wr(8'h14, 8'h04);
    for (i = 0; i < 2; i++) begin
      channel_alert_i = i == 0 ? 8'h02 : 8'h04;
      cyc(2);
      chk("alert", {7'h00, alert_o}, 8'(i));
    end
    wr(8'h11, 8'h30);
    chk("zc_analog", {7'h00, zero_cross_detect_o}, 8'h01);
    {pin_config_i, gpio_level_i, analog_zero_cross_i} = {8'h08, 8'h08, 1'b0};
    cyc(4);
    chk("zc_gpio", {7'h00, zero_cross_detect_o}, 8'h01);
    // Mid-run reset clears every configuration register
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    for (i = 0; i < 5; i++) rd(ta[i], 8'h00);
    chk("map_reset", {6'h00, alert_source_map_o}, 8'h00);
    chk("alert_reset", {7'h00, alert_o}, 8'h00);
    final_report();
  end
endmodule : tb_csc_channel_sequence_config
